// ---- logic/sdb_pkg.sv ----
`default_nettype none
package sdb_pkg;
	// widths of the pin groups and the array word
	localparam int ADDR_W = 13;
	localparam int COL_W = 9;
	localparam int BANK_W = 2;
	localparam int DQ_W = 16;
	localparam int BANKS = 4;
	// address bit that requests automatic precharge
	localparam int AP_BIT = 10;
	// burst length codes on burst_length_code
	localparam logic [2:0] BL_CODE_1 = 3'h0;
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] BL_CODE_FULL = 3'h7;
	// column masks of the varying low bits per burst length
	localparam logic [8:0] BL_MASK_1 = 9'h000;
	localparam logic [8:0] BL_MASK_2 = 9'h001;
	localparam logic [8:0] BL_MASK_4 = 9'h003;
	localparam logic [8:0] BL_MASK_8 = 9'h007;
	localparam logic [8:0] BL_MASK_FULL = 9'h1FF;
	// cas latency codes and their values in clocks
	localparam logic [1:0] CL_CODE_2 = 2'h2;
	localparam logic [1:0] CL_CODE_3 = 2'h3;
	localparam logic [9:0] CL_CLOCKS_2 = 10'h002;
	localparam logic [9:0] CL_CLOCKS_3 = 10'h003;
	// write recovery in clocks before internal precharge
	localparam logic [1:0] WR_CLOCKS = 2'h2;
	// sampled pin group, passed through the two-stage synchroniser
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic hmask;
		logic lmask;
		logic [DQ_W-1:0] dq;
	} sdb_pins_t;
	// pins at reset read as deselect with both masks high
	localparam sdb_pins_t PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
		we_n: 1'b1, bank: 2'h0, addr: 13'h0000, hmask: 1'b1, lmask: 1'b1,
		dq: 16'h0000};
	// one write beat towards the array
	typedef struct packed {
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [1:0] be;
		logic [DQ_W-1:0] data;
	} sdb_wr_word_t;
	localparam int WR_WORD_W = $bits(sdb_wr_word_t);
endpackage
`default_nettype wire

// ---- logic/sdb_wr_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sdb_wr_if #(
	parameter int W = 42
);
	logic valid;
	logic ready;
	logic [W-1:0] word;
	modport sink(input valid, input word, output ready);
	modport source(output valid, output word, input ready);
endinterface
`default_nettype wire

// ---- logic/sdb_skid_buf.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdb_skid_buf #(
	parameter int W = 42
) (
	input wire logic clock,
	input wire logic rst_n,
	sdb_wr_if.sink in_if,
	sdb_wr_if.source out_if
);
	logic out_v_ff;
	logic skid_v_ff;
	logic ready_ff;
	logic [W-1:0] out_ff;
	logic [W-1:0] skid_ff;
	logic push;
	logic drain;

	// two entries: output register plus a skid slot
	assign push = in_if.valid & ready_ff;
	assign drain = ~out_v_ff | out_if.ready;
	assign in_if.ready = ready_ff;
	assign out_if.valid = out_v_ff;
	assign out_if.word = out_ff;

	// ready is registered so it cannot loop back into the source
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_v_ff <= 1'b0;
			skid_v_ff <= 1'b0;
			ready_ff <= 1'b1;
			out_ff <= '0;
			skid_ff <= '0;
		end else if (drain) begin
			if (skid_v_ff) begin
				out_ff <= skid_ff;
				out_v_ff <= 1'b1;
				skid_v_ff <= 1'b0;
				ready_ff <= 1'b1;
			end else begin
				out_ff <= in_if.word;
				out_v_ff <= push;
			end
		end else if (push) begin
			skid_ff <= in_if.word;
			skid_v_ff <= 1'b1;
			ready_ff <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- logic/sdb_burst_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// - row high, column low decodes a column access; write strobe picks direction.
// - a new read or write is accepted every cycle, any open bank.
// - select and column low, row and write high means burst read.
// - burst length 1,2,4,8,full page and ordering come from mode settings.
// - select, column and write low, row high means burst write.
// - write data taken from the command cycle on; data after the burst ignored.
// - a read interrupting a read restarts a full burst; old data drains.
// - a write interrupting a write restarts a full burst at the new column.
// - a read ends a write at once; the controller frees the data bus.
// - burst stop ends the burst, bank stays open, read data ends after latency.
// - sequential bursts count only the low bits and wrap without carry.
// - interleaved bursts xor the low start bits with the beat index; full page stays sequential.
// - auto precharge flag high on a column command closes the bank after it, except in full page.
// - read auto precharge starts latency-dependent clocks before the final beat.
// - write auto precharge starts two clocks after the last beat.
// - read mask floats outputs two cycles later; write mask blocks the byte now.
// - with select high new commands are ignored and bursts carry on.
// - a no-operation never ends a running burst.
module sdb_burst_core
	import sdb_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BANK_W-1:0] bank_select,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	input wire logic [DQ_W-1:0] dq_in,
	output logic [DQ_W-1:0] dq_out,
	output logic [1:0] dq_oe,
	input wire logic [2:0] burst_length_code,
	input wire logic burst_interleave,
	input wire logic [1:0] cas_latency,
	output logic arr_wr_valid,
	input wire logic arr_wr_ready,
	output logic [BANK_W-1:0] arr_wr_bank,
	output logic [ADDR_W-1:0] arr_wr_row,
	output logic [COL_W-1:0] arr_wr_col,
	output logic [1:0] arr_wr_be,
	output logic [DQ_W-1:0] arr_wr_data,
	output logic arr_rd_en,
	output logic [BANK_W-1:0] arr_rd_bank,
	output logic [ADDR_W-1:0] arr_rd_row,
	output logic [COL_W-1:0] arr_rd_col,
	input wire logic [DQ_W-1:0] arr_rd_data,
	output logic [BANKS-1:0] bank_open,
	output logic burst_active,
	output logic wr_path_ready,
	output logic wr_overrun
);
	// synchroniser stages; meta is read by pins_ff only
	sdb_pins_t pins_raw;
	sdb_pins_t meta_ff;
	sdb_pins_t pins_ff;

	// decoded commands
	logic sel;
	logic cmd_act;
	logic cmd_pre;
	logic cmd_rd;
	logic cmd_wr;
	logic cmd_bst;
	logic new_burst;
	logic cont;
	logic beat_go;

	// mode decode
	logic [COL_W-1:0] bl_mask;
	logic full_page;
	logic cl3;
	logic [9:0] cl_clocks;

	// running burst state
	logic run_ff;
	logic run_wr_ff;
	logic run_ap_ff;
	logic [BANK_W-1:0] run_bank_ff;
	logic [COL_W-1:0] start_ff;
	logic [COL_W-1:0] beat_ff;

	// per-bank open flags and rows
	logic [BANKS-1:0] open_ff;
	logic [ADDR_W-1:0] row_tab_ff [BANKS];

	// current beat
	logic b_wr;
	logic b_ap;
	logic [BANK_W-1:0] b_bank;
	logic [COL_W-1:0] b_start;
	logic [COL_W-1:0] b_idx;
	logic [COL_W-1:0] b_col;
	logic [COL_W-1:0] seq_sum;
	logic b_last;
	logic [1:0] b_be;
	logic rd_close;

	// write recovery before automatic precharge
	logic [1:0] wr_rec_ff;
	logic [BANK_W-1:0] wr_rec_bank_ff;
	logic wr_close;

	// read data pipeline
	logic arr_rd_en_ff;
	logic [BANK_W-1:0] arr_rd_bank_ff;
	logic [ADDR_W-1:0] arr_rd_row_ff;
	logic [COL_W-1:0] arr_rd_col_ff;
	logic stage_v_ff;
	logic [DQ_W-1:0] stage_ff;
	logic [1:0] mask_d1_ff;
	logic [DQ_W-1:0] dq_out_ff;
	logic [1:0] dq_oe_ff;
	logic src_v;
	logic wr_overrun_ff;

	// write path buffer
	sdb_wr_word_t in_word;
	sdb_wr_word_t out_word;
	sdb_wr_if #(.W(WR_WORD_W)) buf_in ();
	sdb_wr_if #(.W(WR_WORD_W)) buf_out ();

	// every pin passes two flops before decode
	assign pins_raw = '{cs_n: cs_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n,
		bank: bank_select, addr: addr, hmask: high_byte_mask,
		lmask: low_byte_mask, dq: dq_in};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= PINS_IDLE;
			pins_ff <= PINS_IDLE;
		end else begin
			meta_ff <= pins_raw;
			pins_ff <= meta_ff;
		end
	end

	// command decode; select high leaves only the running burst
	assign sel = ~pins_ff.cs_n;
	assign cmd_act = sel & ~pins_ff.ras_n & pins_ff.cas_n & pins_ff.we_n;
	assign cmd_pre = sel & ~pins_ff.ras_n & pins_ff.cas_n & ~pins_ff.we_n;
	assign cmd_rd = sel & pins_ff.ras_n & ~pins_ff.cas_n & pins_ff.we_n;
	assign cmd_wr = sel & pins_ff.ras_n & ~pins_ff.cas_n & ~pins_ff.we_n;
	assign cmd_bst = sel & pins_ff.ras_n & pins_ff.cas_n & ~pins_ff.we_n;

	// column access to a closed bank is dropped, not guessed at
	assign new_burst = (cmd_rd | cmd_wr) & open_ff[pins_ff.bank];
	// no-operation and deselect fall through to cont
	assign cont = run_ff & ~new_burst & ~cmd_bst;
	assign beat_go = new_burst | cont;

	// burst length and latency from the mode settings
	always_comb begin
		bl_mask = BL_MASK_1;
		case (burst_length_code)
			BL_CODE_1: bl_mask = BL_MASK_1;
			BL_CODE_2: bl_mask = BL_MASK_2;
			BL_CODE_4: bl_mask = BL_MASK_4;
			BL_CODE_8: bl_mask = BL_MASK_8;
			BL_CODE_FULL: bl_mask = BL_MASK_FULL;
			default: bl_mask = BL_MASK_1;
		endcase
	end
	assign full_page = (burst_length_code == BL_CODE_FULL);
	assign cl3 = (cas_latency == CL_CODE_3);
	assign cl_clocks = cl3 ? CL_CLOCKS_3 : CL_CLOCKS_2;

	// the command cycle carries beat 0 itself
	assign b_wr = new_burst ? cmd_wr : run_wr_ff;
	assign b_ap = new_burst ? pins_ff.addr[AP_BIT] : run_ap_ff;
	assign b_bank = new_burst ? pins_ff.bank : run_bank_ff;
	assign b_start = new_burst ? pins_ff.addr[COL_W-1:0] : start_ff;
	assign b_idx = new_burst ? 9'h000 : beat_ff;
	assign seq_sum = b_start + b_idx;

	// column order: carry stays inside the masked low bits
	always_comb begin
		b_col = (b_start & ~bl_mask) | (seq_sum & bl_mask);
		if (burst_interleave && !full_page) begin
			b_col = b_start ^ (b_idx & bl_mask);
		end
	end
	assign b_last = ~full_page & (b_idx == bl_mask);

	// a high mask blocks its byte in the same cycle
	assign b_be = ~{pins_ff.hmask, pins_ff.lmask};

	// read precharge begins latency-minus-one clocks ahead of the last beat
	assign rd_close = beat_go & ~b_wr & b_ap & ~full_page
		& (({1'b0, b_idx} + cl_clocks) > {1'b0, bl_mask});
	assign wr_close = (wr_rec_ff == 2'h1);

	// burst sequencer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			run_ff <= 1'b0;
			run_wr_ff <= 1'b0;
			run_ap_ff <= 1'b0;
			run_bank_ff <= 2'h0;
			start_ff <= 9'h000;
			beat_ff <= 9'h000;
		end else if (new_burst) begin
			run_ff <= ~b_last;
			run_wr_ff <= cmd_wr;
			run_ap_ff <= pins_ff.addr[AP_BIT];
			run_bank_ff <= pins_ff.bank;
			start_ff <= pins_ff.addr[COL_W-1:0];
			beat_ff <= 9'h001;
		end else if (cmd_bst) begin
			run_ff <= 1'b0;
		end else if (cont) begin
			run_ff <= ~b_last;
			beat_ff <= beat_ff + 9'h001;
		end
	end

	// write recovery count after a last auto precharge write beat
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_rec_ff <= 2'h0;
			wr_rec_bank_ff <= 2'h0;
		end else if (beat_go && b_wr && b_ap && b_last) begin
			wr_rec_ff <= WR_CLOCKS;
			wr_rec_bank_ff <= b_bank;
		end else if (wr_rec_ff != 2'h0) begin
			wr_rec_ff <= wr_rec_ff - 2'h1;
		end
	end

	// bank table: closes first, so an activate in the same cycle wins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			open_ff <= 4'h0;
			for (int i = 0; i < BANKS; i++) begin
				row_tab_ff[i] <= 13'h0000;
			end
		end else begin
			if (cmd_pre && pins_ff.addr[AP_BIT]) begin
				open_ff <= 4'h0;
			end else if (cmd_pre) begin
				open_ff[pins_ff.bank] <= 1'b0;
			end
			if (rd_close) begin
				open_ff[b_bank] <= 1'b0;
			end
			if (wr_close) begin
				open_ff[wr_rec_bank_ff] <= 1'b0;
			end
			if (cmd_act) begin
				open_ff[pins_ff.bank] <= 1'b1;
				row_tab_ff[pins_ff.bank] <= pins_ff.addr;
			end
		end
	end

	// write beats into the buffer; a fully masked beat writes nothing
	assign in_word = '{bank: b_bank, row: row_tab_ff[b_bank], col: b_col,
		be: b_be, data: pins_ff.dq};
	assign buf_in.valid = beat_go & b_wr & (|b_be);
	assign buf_in.word = in_word;
	assign buf_out.ready = arr_wr_ready;

	sdb_skid_buf #(.W(WR_WORD_W)) u_wr_buf (
		.clock(clock),
		.rst_n(rst_n),
		.in_if(buf_in),
		.out_if(buf_out)
	);

	// the pins cannot be stalled, so a full buffer is flagged sticky
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_overrun_ff <= 1'b0;
		end else if (buf_in.valid && !buf_in.ready) begin
			wr_overrun_ff <= 1'b1;
		end
	end

	// read address to the array, one beat per cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			arr_rd_en_ff <= 1'b0;
			arr_rd_bank_ff <= 2'h0;
			arr_rd_row_ff <= 13'h0000;
			arr_rd_col_ff <= 9'h000;
		end else begin
			arr_rd_en_ff <= beat_go & ~b_wr;
			arr_rd_bank_ff <= b_bank;
			arr_rd_row_ff <= row_tab_ff[b_bank];
			arr_rd_col_ff <= b_col;
		end
	end

	// latency 3 adds one stage; beats already issued keep draining
	assign src_v = cl3 ? stage_v_ff : arr_rd_en_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage_v_ff <= 1'b0;
			stage_ff <= 16'h0000;
			mask_d1_ff <= 2'h3;
			dq_out_ff <= 16'h0000;
			dq_oe_ff <= 2'h0;
		end else begin
			stage_v_ff <= arr_rd_en_ff;
			stage_ff <= arr_rd_data;
			mask_d1_ff <= {pins_ff.hmask, pins_ff.lmask};
			dq_out_ff <= cl3 ? stage_ff : arr_rd_data;
			dq_oe_ff <= {2{src_v}} & ~mask_d1_ff;
		end
	end

	// outputs straight from flops
	assign out_word = buf_out.word;
	assign arr_wr_valid = buf_out.valid;
	assign arr_wr_bank = out_word.bank;
	assign arr_wr_row = out_word.row;
	assign arr_wr_col = out_word.col;
	assign arr_wr_be = out_word.be;
	assign arr_wr_data = out_word.data;
	assign arr_rd_en = arr_rd_en_ff;
	assign arr_rd_bank = arr_rd_bank_ff;
	assign arr_rd_row = arr_rd_row_ff;
	assign arr_rd_col = arr_rd_col_ff;
	assign dq_out = dq_out_ff;
	assign dq_oe = dq_oe_ff;
	assign bank_open = open_ff;
	assign burst_active = run_ff;
	assign wr_path_ready = buf_in.ready;
	assign wr_overrun = wr_overrun_ff;
endmodule
`default_nettype wire

// ---- verification/sdb_burst_core_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdb_burst_core_props
	import sdb_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BANK_W-1:0] bank_select,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	input wire logic [DQ_W-1:0] dq_out,
	input wire logic [1:0] dq_oe,
	input wire logic [1:0] cas_latency,
	input wire logic arr_wr_valid,
	input wire logic arr_wr_ready,
	input wire logic [COL_W-1:0] arr_wr_col,
	input wire logic [1:0] arr_wr_be,
	input wire logic [DQ_W-1:0] arr_wr_data,
	input wire logic arr_rd_en,
	input wire logic [COL_W-1:0] arr_rd_col,
	input wire logic [DQ_W-1:0] arr_rd_data,
	input wire logic [BANKS-1:0] bank_open,
	input wire logic wr_path_ready
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic col_cmd, rd_cmd, act_cmd, stp_cmd, no_mask;
	// pin decode; the core sees these two edges late through its syncs
	assign col_cmd = !cs_n && ras_n && !cas_n;
	assign rd_cmd = col_cmd && we_n && bank_open[bank_select];
	assign act_cmd = !cs_n && !ras_n && cas_n && we_n;
	assign stp_cmd = !cs_n && ras_n && cas_n && !we_n;
	assign no_mask = !low_byte_mask && !high_byte_mask;

	// beat 0 leaves the decode cycle, so its address stands after the third edge
	a_rd_issue: assert property (rd_cmd |-> ##3 arr_rd_en && arr_rd_col == $past(addr[8:0], 3))
		else $error("read beat not issued at its column");
	a_rd_lat_two: assert property (rd_cmd && no_mask && cas_latency == CL_CODE_2 |-> ##4
		dq_oe == 2'h3 && dq_out == $past(arr_rd_data, 1))
		else $error("first read word late at latency two");
	// at latency three the mask that counts is the one a cycle after the command
	a_rd_lat_three: assert property (rd_cmd && cas_latency == CL_CODE_3 ##1 no_mask |-> ##4
		dq_oe == 2'h3 && dq_out == $past(arr_rd_data, 2))
		else $error("first read word late at latency three");
	a_act_opens: assert property (act_cmd |-> ##4 bank_open[$past(bank_select, 4)])
		else $error("activate left bank closed");
	a_stop_halts: assert property (stp_cmd ##1 !col_cmd |-> ##2 !arr_rd_en [*2])
		else $error("beats issued after burst stop");
	a_wr_hold: assert property (arr_wr_valid && !arr_wr_ready |=>
		arr_wr_valid && $stable(arr_wr_data) && $stable(arr_wr_col))
		else $error("array word changed while stalled");
	a_wr_be_live: assert property (arr_wr_valid |-> arr_wr_be != 2'h0)
		else $error("fully masked beat reached array");
	a_full_buf: assert property (!wr_path_ready |-> arr_wr_valid)
		else $error("buffer refuses while holding nothing");
endmodule

bind sdb_burst_core sdb_burst_core_props u_props (.*);
`default_nettype wire

// ---- verification/sdb_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdb_ctrl_model
	import sdb_pkg::*;
#(
	parameter int RCD = 2
) (
	input wire logic clock,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [BANK_W-1:0] bank_select,
	output logic [ADDR_W-1:0] addr,
	output logic low_byte_mask,
	output logic high_byte_mask,
	output logic [DQ_W-1:0] dq_in
);
	// deselected from time zero so the syncs flush clean values
	initial begin
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		bank_select = 2'h0;
		addr = 13'h0000;
		{high_byte_mask, low_byte_mask} = 2'h0;
		dq_in = 16'h0000;
	end
	// one command slot, changed on the falling edge and held a full cycle
	task automatic put(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
		input logic [1:0] m, input logic [15:0] d);
		@(negedge clock);
		{cs_n, ras_n, cas_n, we_n} <= c;
		bank_select <= b;
		addr <= a;
		{high_byte_mask, low_byte_mask} <= m;
		dq_in <= d;
	endtask
	// released bus keeps toggling so stale data never looks valid
	task automatic nop();
		put(4'h7, bank_select, addr, 2'h0, ~dq_in);
	endtask
	// the row-to-column wait also spaces activates to other banks
	task automatic act(input logic [1:0] b, input logic [12:0] r);
		put(4'h3, b, r, 2'h0, ~dq_in);
		repeat (RCD) nop();
	endtask
endmodule
`default_nettype wire

// ---- verification/sdb_burst_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdb_burst_core_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, ras_n, cas_n, we_n, low_byte_mask, high_byte_mask, burst_interleave;
	logic arr_wr_ready, arr_wr_valid, arr_rd_en, burst_active, wr_path_ready, wr_overrun;
	logic [1:0] bank_select, cas_latency, dq_oe, arr_wr_be, arr_wr_bank, arr_rd_bank;
	logic [2:0] burst_length_code;
	logic [12:0] addr, arr_wr_row, arr_rd_row;
	logic [8:0] arr_wr_col, arr_rd_col;
	logic [15:0] dq_in, dq_out, arr_wr_data, arr_rd_data;
	logic [3:0] bank_open;
	logic [12:0] row_of [4] = '{13'h0005, 13'h0009, 13'h0012, 13'h001C};
	logic [15:0] rq [$];
	logic [28:0] wq [$];
	logic [28:0] w;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed = 32'h3180EE89;

	// array stand-in: each word encodes its own address, so beats are traceable
	assign arr_rd_data = {arr_rd_bank, arr_rd_row[4:0], arr_rd_col};
	sdb_burst_core u_dut (.*);
	sdb_ctrl_model u_ctrl (.*);
	always #12.5 clock = ~clock;

	task automatic check(input logic [28:0] seen, input logic [28:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// column of beat k, from the current length code and order
	function automatic logic [8:0] col_at(input logic [8:0] s, input int k);
		logic [8:0] m;
		m = (burst_length_code == 3'h7) ? 9'h1FF : (9'h001 << burst_length_code) - 9'h001;
		if (burst_interleave && burst_length_code != 3'h7) begin
			return s ^ (9'(k) & m);
		end
		return (s & ~m) | ((s + 9'(k)) & m);
	endfunction
	task automatic idle(input int n);
		repeat (n) u_ctrl.nop();
	endtask
	// n is how many beats should really emerge, fewer when cut short
	task automatic rd(input logic [1:0] b, input logic [8:0] s, input int n, input logic ap);
		u_ctrl.put(4'h5, b, {2'h0, ap, 1'b0, s}, 2'h0, ~dq_in);
		for (int k = 0; k < n; k++) begin
			rq.push_back({b, row_of[b][4:0], col_at(s, k)});
		end
	endtask
	// mask mk applies to beat 1 only; a fully masked beat is expected nowhere
	task automatic wr(input logic [1:0] b, input logic [8:0] s, input int n, input logic ap,
		input logic [1:0] mk);
		logic [15:0] d;
		for (int k = 0; k < n; k++) begin
			d = 16'($random(seed));
			u_ctrl.put(k == 0 ? 4'h4 : 4'h7, b, {2'h0, ap, 1'b0, s}, k == 1 ? mk : 2'h0, d);
			if (!(k == 1 && mk == 2'h3)) begin
				wq.push_back({b, col_at(s, k), k == 1 ? ~mk : 2'h3, d});
			end
		end
	endtask

	// scoreboard: each read beat and accepted array word takes the oldest note
	always @(posedge clock) begin
		cyc++;
		if (cyc > 3000) begin
			bad_count++;
			finish_test();
		end
		if (rst_n && dq_oe !== 2'h0) begin
			if (rq.size() == 0) begin
				check(29'h1, 29'h0);
			end else begin
				check(29'({dq_oe, dq_out}), 29'({2'h3, rq.pop_front()}));
			end
		end
		if (rst_n && arr_wr_valid && arr_wr_ready) begin
			if (wq.size() == 0) begin
				check(29'h1, 29'h0);
			end else begin
				w = wq.pop_front();
				check({arr_wr_bank, arr_wr_col, arr_wr_be, arr_wr_data}, w);
				check(29'(arr_wr_row), 29'(row_of[w[28:27]]));
			end
		end
	end

	initial begin
		burst_length_code = 3'h0;
		burst_interleave = 1'b0;
		cas_latency = 2'h2;
		arr_wr_ready = 1'b1;
		repeat (5) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		for (int b = 0; b < 4; b++) begin
			u_ctrl.act(2'(b), row_of[b]);
		end
		// length codes for 1 to 8 beats, not full page, with both orders and latencies, random start column
		for (int i = 0; i < 16; i++) begin
			burst_length_code = 3'(i % 4);
			burst_interleave = i[2];
			cas_latency = i[3] ? 2'h3 : 2'h2;
			rd(2'(i), 9'($random(seed)), 1 << (i % 4), 1'b0);
			idle(12);
		end
		// reads back to back across banks; older beat drains before restart
		burst_length_code = 3'h2;
		rd(2'h0, 9'h0F3, 1, 1'b0);
		rd(2'h1, 9'h040, 1, 1'b0);
		rd(2'h1, 9'h1FE, 4, 1'b0);
		idle(12);
		// stop after two of eight beats, then a full page wrapping the row
		burst_length_code = 3'h3;
		rd(2'h2, 9'h011, 2, 1'b0);
		idle(1);
		u_ctrl.put(4'h6, 2'h2, 13'h0000, 2'h0, ~dq_in);
		idle(12);
		burst_length_code = 3'h7;
		rd(2'h3, 9'h1FE, 4, 1'b0);
		idle(3);
		check(29'(burst_active), 29'h1);
		u_ctrl.put(4'h6, 2'h3, 13'h0000, 2'h0, ~dq_in);
		idle(12);
		check(29'(burst_active), 29'h0);
		// deselected read strobes and no-ops in mid burst change nothing
		burst_length_code = 3'h3;
		rd(2'h0, 9'h005, 8, 1'b0);
		u_ctrl.put(4'hD, 2'h1, 13'h0000, 2'h0, ~dq_in);
		idle(1);
		u_ctrl.put(4'hD, 2'h2, 13'h0044, 2'h0, ~dq_in);
		// read data drains fully before the first write, so no mask is owed
		idle(12);
		// masked beat, write over write, read over write
		burst_length_code = 3'h2;
		wr(2'h1, 9'h0A1, 4, 1'b0, 2'h1);
		idle(2);
		wr(2'h1, 9'h0B2, 2, 1'b0, 2'h3);
		wr(2'h1, 9'h0C7, 4, 1'b0, 2'h0);
		idle(2);
		wr(2'h2, 9'h033, 1, 1'b0, 2'h0);
		rd(2'h2, 9'h100, 4, 1'b0);
		idle(12);
		// stalled array: two words fill the buffer until it refuses, then drain
		burst_length_code = 3'h1;
		arr_wr_ready = 1'b0;
		wr(2'h3, 9'h010, 2, 1'b0, 2'h0);
		idle(6);
		check(29'({wr_path_ready, arr_wr_valid}), 29'h1);
		arr_wr_ready = 1'b1;
		idle(6);
		check(29'(wr_path_ready), 29'h1);
		// auto precharge closes after write recovery and before the read burst's last beat
		wr(2'h0, 9'h020, 2, 1'b1, 2'h0);
		idle(3);
		rd(2'h1, 9'h077, 2, 1'b1);
		idle(10);
		check(29'(bank_open), 29'hC);
		rd(2'h0, 9'h000, 0, 1'b0);
		u_ctrl.put(4'h2, 2'h2, 13'h0000, 2'h0, ~dq_in);
		idle(8);
		check(29'(bank_open), 29'h8);
		// precharge all, then a fresh activate reopens one bank
		u_ctrl.put(4'h2, 2'h0, 13'h0400, 2'h0, ~dq_in);
		idle(4);
		check(29'(bank_open), 29'h0);
		u_ctrl.act(2'h1, row_of[1]);
		idle(1);
		check(29'(bank_open), 29'h2);
		check(29'(wr_overrun), 29'h0);
		check(29'(rq.size() + wq.size()), 29'h0);
		finish_test();
	end
endmodule
`default_nettype wire
